// [design/cfg_prot_pkg.sv]
package cfg_prot_pkg;
    // Configuration word widths and fields
    localparam int FUSE_W = 14;
    localparam int PER_W = 5;
    localparam int WIN_W = 3;
    localparam int WP_W = 2;
    localparam int PM_AW = 16;
    localparam int CPS_LSB = 0;
    localparam int CWS_LSB = 8;
    localparam int CP_BIT = 7;
    localparam int WRT_LSB = 0;
    // Period select decode
    localparam logic [4:0] PER_LAST_POW = 5'h12;
    localparam logic [4:0] PER_SW_CODE = 5'h1F;
    localparam logic [4:0] PER_SW_INIT = 5'h0B;
    localparam logic [4:0] PER_MIN_CODE = 5'h00;
    localparam logic [4:0] PER_POW_BASE = 5'h05;
    // Window select: codes 110/111 give software control
    localparam logic [2:0] WIN_SW_MIN = 3'h6;
    localparam logic [2:0] WIN_OPEN = 3'h7;
    localparam logic [2:0] WIN_FUSE_MIN = 3'h1;
    // Write protection field encoding and limits
    localparam logic [1:0] WRT_OFF = 2'h3;
    localparam logic [1:0] WRT_BOOT = 2'h2;
    localparam logic [1:0] WRT_HALF = 2'h1;
    localparam logic [15:0] WRT_BOOT_TOP = 16'h01FF;
    localparam logic [15:0] WRT_HALF_TOP = 16'h0FFF;
    localparam logic [15:0] WRT_ALL_TOP = 16'h1FFF;
    // Special locations
    localparam logic [15:0] UID_BASE = 16'h8000;
    localparam logic [15:0] UID_TOP = 16'h8003;
    localparam logic [15:0] REV_ADDR = 16'h8005;
    localparam logic [15:0] PART_IDENT_WORD_ADDR = 16'h8006;
    // APB map: fuse-driven state, user IDs and identity words exposed to software
    localparam logic [11:0] A_PERIOD = 12'h000;
    localparam logic [11:0] A_WINDOW = 12'h004;
    localparam logic [11:0] A_FUSE3 = 12'h008;
    localparam logic [11:0] A_STATUS = 12'h00C;
    localparam logic [11:0] A_UID0 = 12'h010;
    localparam logic [11:0] A_REV = 12'h020;
    localparam logic [11:0] A_PART_IDENT_WORD = 12'h024;
    localparam int UID_N = 4;
    // External programmer request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [13:0] wdata;
    } pm_req_s;
endpackage

// [design/config_protection_and_ids.sv]
`timescale 1ns/10ps
`default_nettype none
module config_protection_and_ids #(
    // Arbitrary neutral identity values
    parameter logic [13:0] PART_ID = 14'h0A5A,
    parameter logic [13:0] REV_ID = 14'h0101
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Fuse words, valid at reset release
    input wire logic [cfg_prot_pkg::FUSE_W-1:0] fuse2_word,
    input wire logic [cfg_prot_pkg::FUSE_W-1:0] fuse3_word,
    input wire logic [cfg_prot_pkg::FUSE_W-1:0] fuse1_word,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External programmer path
    input wire cfg_prot_pkg::pm_req_s ext_req,
    output logic [13:0] ext_rdata,
    output logic ext_wr_grant,
    // CPU program-memory path
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [15:0] cpu_addr,
    input wire logic [13:0] cpu_wdata,
    output logic [13:0] cpu_rdata,
    output logic cpu_wr_grant,
    // Program array data and watchdog outputs
    input wire logic [13:0] pm_rdata,
    output logic [4:0] watchdog_live_period,
    output logic [4:0] wdt_div_log2,
    output logic [2:0] wdt_window
);
    import cfg_prot_pkg::*;

    typedef enum logic [1:0] {ST_CAPTURE, ST_RUN} phase_e;
    phase_e phase_q;
    logic [4:0] watchdog_cfg_period_select;
    logic [2:0] win_cfg_q;
    logic code_protect_n;
    logic [1:0] self_write_protect_sel;
    logic [13:0] third_fuse_word;
    logic [13:0] uid_q [UID_N];
    logic per_sw, win_sw;
    logic wr_acc;

    // Top of the protected block, or none
    function automatic logic wp_hit(input logic [1:0] sel,
                                    input logic [15:0] a);
        case (sel)
            WRT_OFF: wp_hit = 1'b0;
            WRT_BOOT: wp_hit = (a <= WRT_BOOT_TOP);
            WRT_HALF: wp_hit = (a <= WRT_HALF_TOP);
            default: wp_hit = (a <= WRT_ALL_TOP);
        endcase
    endfunction

    // Locations that can never be altered
    function automatic logic id_loc(input logic [15:0] a);
        id_loc = (a == REV_ADDR) || (a == PART_IDENT_WORD_ADDR);
    endfunction

    function automatic logic uid_loc(input logic [15:0] a);
        uid_loc = (a >= UID_BASE) && (a <= UID_TOP);
    endfunction

    // Special-location read mux shared by both paths
    function automatic logic [13:0] rd_mux(input logic [15:0] a,
                                           input logic [13:0] arr,
                                           input logic [13:0] u);
        if (a == PART_IDENT_WORD_ADDR) begin
            rd_mux = PART_ID;
        end else if (a == REV_ADDR) begin
            rd_mux = REV_ID;
        end else if (uid_loc(a)) begin
            rd_mux = u;
        end else begin
            rd_mux = arr;
        end
    endfunction

    // Fuse capture: one cycle after reset release, then frozen, so a
    // programmer rewriting fuses mid-run has no effect until reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_q <= ST_CAPTURE;
            watchdog_cfg_period_select <= 5'h00;
            win_cfg_q <= 3'h0;
            code_protect_n <= 1'b0;
            self_write_protect_sel <= 2'h0;
            third_fuse_word <= 14'h0000;
        end else if (ce) begin
            case (phase_q)
                ST_CAPTURE: begin
                    watchdog_cfg_period_select <=
                        fuse3_word[CPS_LSB +: PER_W];
                    win_cfg_q <= fuse3_word[CWS_LSB +: WIN_W];
                    code_protect_n <= fuse1_word[CP_BIT];
                    self_write_protect_sel <=
                        fuse2_word[WRT_LSB +: WP_W];
                    third_fuse_word <= fuse3_word;
                    phase_q <= ST_RUN;
                end
                ST_RUN: phase_q <= ST_RUN;
                default: phase_q <= ST_CAPTURE;
            endcase
        end
    end

    assign per_sw = (watchdog_cfg_period_select == PER_SW_CODE);
    assign win_sw = (win_cfg_q >= WIN_SW_MIN);
    assign wr_acc = psel && penable && pwrite;

    // Live period: preset on capture, software writes only in code 31
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_live_period <= 5'h00;
        end else if (ce) begin
            if (phase_q == ST_CAPTURE) begin
                if (fuse3_word[CPS_LSB +: PER_W] == PER_SW_CODE) begin
                    watchdog_live_period <= PER_SW_INIT;
                end else begin
                    watchdog_live_period <= fuse3_word[CPS_LSB +: PER_W];
                end
            end else if (wr_acc && paddr == A_PERIOD && per_sw) begin
                watchdog_live_period <= pwdata[4:0];
            end
        end
    end

    // Window: fuse codes 110 and 111 both open fully, so the 12.5%
    // delay code 110 is reachable only by a software write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdt_window <= WIN_OPEN;
        end else if (ce) begin
            if (phase_q == ST_CAPTURE) begin
                if (fuse3_word[CWS_LSB +: WIN_W] >= WIN_SW_MIN) begin
                    wdt_window <= WIN_OPEN;
                end else begin
                    wdt_window <= fuse3_word[CWS_LSB +: WIN_W];
                end
            end else if (wr_acc && paddr == A_WINDOW && win_sw) begin
                wdt_window <= pwdata[2:0];
            end
        end
    end

    // Divider exponent; unused codes fall back to the shortest period
    always_comb begin
        if (watchdog_live_period <= PER_LAST_POW) begin
            wdt_div_log2 = watchdog_live_period + PER_POW_BASE;
        end else begin
            wdt_div_log2 = PER_MIN_CODE + PER_POW_BASE;
        end
    end

    // User ID storage: CPU self-write, external write if unprotected
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < UID_N; i++) begin
                uid_q[i] <= 14'h3FFF;
            end
        end else if (ce) begin
            if (cpu_wr && uid_loc(cpu_addr)) begin
                uid_q[cpu_addr[1:0]] <= cpu_wdata;
            end else if (ext_req.wr && code_protect_n &&
                         uid_loc(ext_req.addr)) begin
                uid_q[ext_req.addr[1:0]] <= ext_req.wdata;
            end
        end
    end

    // Write grants to the array; ID words never granted
    assign cpu_wr_grant = cpu_wr && (phase_q == ST_RUN) &&
        !id_loc(cpu_addr) && !uid_loc(cpu_addr) &&
        !wp_hit(self_write_protect_sel, cpu_addr);
    assign ext_wr_grant = ext_req.wr && code_protect_n &&
        (phase_q == ST_RUN) && !id_loc(ext_req.addr) &&
        !uid_loc(ext_req.addr);

    // Registered read data; CPU sees through protection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 14'h0000;
            ext_rdata <= 14'h0000;
        end else if (ce) begin
            if (cpu_rd) begin
                cpu_rdata <= rd_mux(cpu_addr, pm_rdata,
                                    uid_q[cpu_addr[1:0]]);
            end
            if (ext_req.rd) begin
                ext_rdata <= code_protect_n ?
                    rd_mux(ext_req.addr, pm_rdata,
                           uid_q[ext_req.addr[1:0]]) : 14'h0000;
            end
        end
    end

    // APB: zero-wait; unmapped or bad write gives pslverr
    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                A_PERIOD: pslverr = pwrite && !per_sw;
                A_WINDOW: pslverr = pwrite && !win_sw;
                A_UID0, A_UID0 + 12'h004, A_UID0 + 12'h008,
                A_UID0 + 12'h00C: pslverr = 1'b0;
                A_FUSE3, A_STATUS, A_REV, A_PART_IDENT_WORD: pslverr = pwrite;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // APB read data register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            case (paddr)
                A_PERIOD: prdata <= {27'h0, watchdog_live_period};
                A_WINDOW: prdata <= {29'h0, wdt_window};
                A_FUSE3: prdata <= {18'h0, third_fuse_word};
                A_STATUS: prdata <= {22'h0, win_sw, per_sw,
                    code_protect_n, self_write_protect_sel, wdt_div_log2};
                A_UID0: prdata <= {18'h0, uid_q[0]};
                A_UID0 + 12'h004: prdata <= {18'h0, uid_q[1]};
                A_UID0 + 12'h008: prdata <= {18'h0, uid_q[2]};
                A_UID0 + 12'h00C: prdata <= {18'h0, uid_q[3]};
                A_REV: prdata <= {18'h0, REV_ID};
                A_PART_IDENT_WORD: prdata <= {18'h0, PART_ID};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions: watchdog period and window decode
    a_div_fixed_short: assert property (
        @(posedge mclk) disable iff (rst)
        watchdog_live_period > PER_LAST_POW |-> wdt_div_log2 == 5'h05)
        else $error("fixed code must divide by 32");
    a_div_power_map: assert property (
        @(posedge mclk) disable iff (rst)
        watchdog_live_period <= PER_LAST_POW |->
        wdt_div_log2 == watchdog_live_period + 5'h05)
        else $error("divider exponent wrong");
    a_sw_period_init: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && phase_q == ST_CAPTURE && fuse3_word[4:0] == 5'h1F) |=>
        watchdog_live_period == 5'h0B)
        else $error("software period not preset");
    a_period_locked: assert property (
        @(posedge mclk) disable iff (rst)
        (phase_q == ST_RUN && !per_sw) |=> $stable(watchdog_live_period))
        else $error("locked period changed");
    a_window_floor: assert property (
        @(posedge mclk) disable iff (rst)
        (phase_q == ST_RUN && !win_sw) |->
        wdt_window == win_cfg_q && wdt_window != WIN_SW_MIN)
        else $error("12.5 percent delay window from fuse");

    // Assertions: external and self-write protection
    a_cp_read_zero: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && ext_req.rd && !code_protect_n && phase_q == ST_RUN) |=>
        ext_rdata == 14'h0000)
        else $error("protected read leaked data");
    a_cp_no_write: assert property (
        @(posedge mclk) disable iff (rst)
        !code_protect_n |-> !ext_wr_grant)
        else $error("protected write granted");
    a_cpu_read_through: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && cpu_rd && cpu_addr <= WRT_ALL_TOP) |=>
        cpu_rdata == $past(pm_rdata))
        else $error("CPU program read altered");
    a_wp_boot: assert property (
        @(posedge mclk) disable iff (rst)
        (self_write_protect_sel == WRT_BOOT && cpu_addr <= WRT_BOOT_TOP)
        |-> !cpu_wr_grant)
        else $error("write into boot block");
    a_wp_block: assert property (
        @(posedge mclk) disable iff (rst)
        (self_write_protect_sel == 2'h0 && cpu_addr <= 16'h1FFF)
        |-> !cpu_wr_grant)
        else $error("write into protected block");

    // Assertions: identity words and held fuse fields
    a_id_readonly: assert property (
        @(posedge mclk) disable iff (rst)
        (cpu_addr == 16'h8006 || cpu_addr == 16'h8005) |-> !cpu_wr_grant)
        else $error("ID word write granted");
    a_ext_id_refuse: assert property (
        @(posedge mclk) disable iff (rst)
        (ext_req.wr && (ext_req.addr == REV_ADDR ||
        ext_req.addr == PART_IDENT_WORD_ADDR)) |-> !ext_wr_grant)
        else $error("ID word external write granted");
    a_cpu_part_ident_word: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && cpu_rd && cpu_addr == 16'h8006) |=> cpu_rdata == PART_ID)
        else $error("part id read wrong");
    a_rev_read: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && cpu_rd && cpu_addr == REV_ADDR) |=> cpu_rdata == REV_ID)
        else $error("revision read wrong");
    a_fuse_hold: assert property (
        @(posedge mclk) disable iff (rst)
        phase_q == ST_RUN |=> $stable(code_protect_n) &&
        $stable(self_write_protect_sel))
        else $error("fuse fields changed in run");

    // Main scenarios
    c_sw_period_write: cover property (@(posedge mclk) disable iff (rst)
        wr_acc && paddr == A_PERIOD && per_sw);
    c_sw_window_write: cover property (@(posedge mclk) disable iff (rst)
        wr_acc && paddr == A_WINDOW && win_sw);
    c_protected_read: cover property (@(posedge mclk) disable iff (rst)
        ext_req.rd && !code_protect_n);
    c_uid_write: cover property (@(posedge mclk) disable iff (rst)
        cpu_wr && uid_loc(cpu_addr));
    c_boot_refuse: cover property (@(posedge mclk) disable iff (rst)
        cpu_wr && !cpu_wr_grant && self_write_protect_sel == WRT_BOOT);
endmodule
`default_nettype wire

// [verif/ext_prog_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Programmer stand-in plus the program array behind the block
module ext_prog_model (
    // Clock
    input wire logic mclk,
    // Programmer request and answers
    output cfg_prot_pkg::pm_req_s ext_req,
    input wire logic [13:0] ext_rdata,
    input wire logic ext_wr_grant,
    // Array read port seen from the CPU side
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_addr,
    output logic [13:0] pm_rdata
);
    import cfg_prot_pkg::*;
    logic [13:0] last_q = 14'h0000;
    initial ext_req = '0;
    // Idle array lines flip every cycle so no stale word can match
    always_comb begin
        if (cpu_rd)
            pm_rdata = cpu_addr[13:0] ^ 14'h155A;
        else if (ext_req.rd)
            pm_rdata = ext_req.addr[13:0] ^ 14'h155A;
        else
            pm_rdata = ~last_q;
    end
    // Last array word, for the idle pattern
    always @(posedge mclk) begin
        last_q <= pm_rdata;
    end
    // One read or write; request held for one full cycle
    task automatic xfer(input logic rd, input logic [15:0] a,
                        input logic [13:0] d, output logic [13:0] q,
                        output logic g);
        @(posedge mclk);
        ext_req <= '{rd: rd, wr: !rd, addr: a, wdata: d};
        #1 g = ext_wr_grant;
        @(posedge mclk);
        ext_req <= '0;
        #1 q = ext_rdata;
    endtask
endmodule
`default_nettype wire

// [verif/test_config_protection_and_ids.sv]
`timescale 1ns/10ps
`default_nettype none
module test_config_protection_and_ids;
    import cfg_prot_pkg::*;
    localparam logic [13:0] PART = 14'h0A5A; // Arbitrary value
    localparam logic [13:0] REV = 14'h0101; // Arbitrary value
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic cpu_rd = 0, cpu_wr = 0, pready, pslverr, ext_wr_grant, cpu_wr_grant;
    logic [13:0] fuse1_word = 14'h3FFF, fuse2_word = 14'h3FFF;
    logic [13:0] fuse3_word = 14'h3FFF, cpu_wdata = 0;
    logic [13:0] ext_rdata, cpu_rdata, pm_rdata, uid [4];
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [15:0] cpu_addr = 0;
    logic [15:0] edges [5] = '{16'h01FF, 16'h0200, 16'h0FFF, 16'h1000, 16'h1FFF};
    logic [4:0] watchdog_live_period, wdt_div_log2;
    logic [2:0] wdt_window;
    pm_req_s ext_req;
    int n_errors = 0, n_compared = 0;
    always #5 mclk = ~mclk;
    // Block under test; clock enable left running
    config_protection_and_ids #(.PART_ID(PART), .REV_ID(REV))
        config_protection_and_ids_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
        .fuse2_word(fuse2_word), .fuse3_word(fuse3_word),
        .fuse1_word(fuse1_word), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_req(ext_req),
        .ext_rdata(ext_rdata), .ext_wr_grant(ext_wr_grant), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_wr_grant(cpu_wr_grant),
        .pm_rdata(pm_rdata), .watchdog_live_period(watchdog_live_period),
        .wdt_div_log2(wdt_div_log2), .wdt_window(wdt_window));
    ext_prog_model ext_prog_model_inst (.mclk(mclk), .ext_req(ext_req),
        .ext_rdata(ext_rdata), .ext_wr_grant(ext_wr_grant), .cpu_rd(cpu_rd),
        .cpu_addr(cpu_addr), .pm_rdata(pm_rdata));
    // Divider exponent expected for a live period code
    function automatic logic [4:0] exp_div(input logic [4:0] c);
        return (c <= 5'h12) ? c + 5'h05 : 5'h05;
    endfunction
    // Self-write allowed outside the protected block
    function automatic logic wp_ok(input logic [1:0] w, input logic [15:0] a);
        case (w)
            2'h3: return 1'b1;
            2'h2: return a > 16'h01FF;
            2'h1: return a > 16'h0FFF;
            default: return 1'b0;
        endcase
    endfunction
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // APB transfer; waits on pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int i;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50) begin
            n_errors++;
            test_done();
        end else begin
            q = prdata;
            e = pslverr;
            psel <= 0;
            penable <= 0;
            #1;
        end
    endtask
    // CPU access; grant seen in the request cycle, data one edge later
    task automatic cpu(input logic wr, input logic [15:0] a,
                       input logic [13:0] d, output logic [13:0] q,
                       output logic g);
        @(posedge mclk);
        cpu_rd <= !wr;
        cpu_wr <= wr;
        cpu_addr <= a;
        cpu_wdata <= d;
        #1 g = cpu_wr_grant;
        @(posedge mclk);
        cpu_rd <= 0;
        cpu_wr <= 0;
        #1 q = cpu_rdata;
    endtask
    // One fuse set: capture, then software, external and CPU traffic
    task automatic run_cfg(input logic [4:0] per, input logic [2:0] win,
                           input logic [1:0] wp, input logic cp);
        logic [31:0] q;
        logic e, g;
        logic [13:0] r;
        logic [15:0] a;
        logic [4:0] live, v, dv;
        logic [2:0] wexp;
        logic [13:0] c3;
        int i;
        // Start on an edge so every input moves with the clock
        @(posedge mclk);
        c3 = {3'h1, win, 1'b1, 2'h3, per};
        fuse3_word <= c3;
        fuse2_word <= {12'hFFF, wp};
        fuse1_word <= {6'h3F, cp, 7'h7F};
        rst <= 1;
        repeat (20) @(posedge mclk);
        rst <= 0;
        repeat (3) @(posedge mclk);
        live = (per == 5'h1F) ? 5'h0B : per;
        wexp = (win >= 3'h6) ? 3'h7 : win;
        check(watchdog_live_period, live);
        check(wdt_div_log2, exp_div(live));
        check(wdt_window, wexp);
        // Fuse pins move after capture; nothing may follow them
        fuse3_word <= ~fuse3_word;
        fuse2_word <= ~fuse2_word;
        fuse1_word <= ~fuse1_word;
        v = 5'($urandom_range(18, 0));
        apb(1, A_PERIOD, {27'h0, v}, q, e);
        dv = (per == 5'h1F) ? v + 5'h05 : exp_div(live);
        check(e, per != 5'h1F);
        check(watchdog_live_period, (per == 5'h1F) ? v : live);
        check(wdt_div_log2, dv);
        apb(1, A_WINDOW, 32'h6, q, e);
        check(e, win < 3'h6);
        check(wdt_window, (win >= 3'h6) ? 3'h6 : wexp);
        apb(0, A_STATUS, 32'h0, q, e);
        check(q[9:0], {win >= 3'h6, per == 5'h1F, cp, wp, dv});
        apb(0, A_FUSE3, 32'h0, q, e);
        check(q, {18'h0, c3});
        a = 16'($urandom_range(16'h1FFF, 0));
        ext_prog_model_inst.xfer(1, a, 14'h0, r, g);
        check(r, cp ? (a[13:0] ^ 14'h155A) : 14'h0);
        ext_prog_model_inst.xfer(0, a, 14'h1234, r, g);
        check(g, cp);
        cpu(0, a, 14'h0, r, g);
        check(r, a[13:0] ^ 14'h155A);
        for (i = 0; i < 5; i++) begin
            cpu(1, edges[i], 14'h2AAA, r, g);
            check(g, wp_ok(wp, edges[i]));
        end
        // Identity words refuse writes and keep their constants
        cpu(1, PART_IDENT_WORD_ADDR, 14'h0, r, g);
        check(g, 1'b0);
        ext_prog_model_inst.xfer(0, REV_ADDR, 14'h0, r, g);
        check(g, 1'b0);
        cpu(0, PART_IDENT_WORD_ADDR, 14'h0, r, g);
        check(r, PART);
        cpu(0, REV_ADDR, 14'h0, r, g);
        check(r, REV);
        apb(0, A_PART_IDENT_WORD, 32'h0, q, e);
        check(q, {18'h0, PART});
        apb(0, A_REV, 32'h0, q, e);
        check(q, {18'h0, REV});
        apb(0, 12'h100, 32'h0, q, e);
        check({e, q}, {1'b1, 32'h0});
        // All user words written before any is read, to catch aliasing
        for (i = 0; i < 4; i++) begin
            uid[i] = 14'($urandom);
            cpu(1, UID_BASE + 16'(i), uid[i], r, g);
        end
        for (i = 0; i < 4; i++) begin
            cpu(0, UID_BASE + 16'(i), 14'h0, r, g);
            check(r, uid[i]);
            apb(0, A_UID0 + 12'(4 * i), 32'h0, q, e);
            check(q, {18'h0, uid[i]});
        end
    endtask
    initial begin
        int c;
        void'($urandom(32'h46e3));
        run_cfg(5'h1F, 3'h6, 2'h0, 1'b0);
        run_cfg(5'h1F, 3'h0, 2'h3, 1'b1);
        for (c = 0; c < 32; c++)
            run_cfg(5'(c), 3'($urandom), 2'($urandom), 1'($urandom));
        test_done();
    end
endmodule
`default_nettype wire
